// ==== src/mcd_defines.vh ====
// mcd_defines.vh: shared constants for the multi-channel dma engine
// Operation
// [R1] word length uses low thirteen bits
// [R2] configured length caps variable length
// [R3] software sets length to maximum plus one
// [R4] variable options add one, zero, two, three
// [R5] seven or eight length bits, bytes only
// [R6] arming copies addresses into working pointers
// [R7] pointers fixed, plus one, plus two, minus one
// [R8] each channel senses one selected trigger
// [R9] single modes: one transfer per trigger
// [R10] block modes: whole count per trigger
// [R11] width selects byte or word transfers
// [R12] priority arbitration with round-robin ties
// [R13] high, normal, low against the cpu
// [R14] eight-byte descriptor fetched after arming
// [R15] channel 0 own pointer, 1-4 shared
// [R16] abort bit disarms selected channels
// [R17] software writes 0 for kept channels
// [R18] completion flag set regardless of mask
// [R19] software clears flag before mask change
// [R20] data space big-endian, special registers little-endian
// [R21] fetch before trigger, triggers meanwhile lost
// [R22] software request bit starts a transfer
// [R23] code 0 none, code 1 previous channel
// [R24] descriptor bytes 0-3 hold addresses
// [R25] one memory access per clock, read then write
`ifndef MCD_DEFINES_VH
`define MCD_DEFINES_VH
// apb register byte offsets
`define MCD_A_ARM 12'h000
`define MCD_A_SWREQ 12'h004
`define MCD_A_FLAG 12'h008
`define MCD_A_PTR0 12'h00c
`define MCD_A_PTR1 12'h010
`define MCD_A_STAT 12'h014
`define MCD_ABORT_BIT 7
`define MCD_PTR_RST 16'h0000
// descriptor layout
`define MCD_DESC_LAST 3'h7
`define MCD_WORD_BIT 7
`define MCD_IRQM_BIT 3
`define MCD_M8_BIT 2
// codes
`define MCD_TRIG_NONE 5'h00
`define MCD_TRIG_PREV 5'h01
`define MCD_TM_SINGLE 2'h0
`define MCD_TM_BLOCK 2'h1
`define MCD_TM_RSINGLE 2'h2
`define MCD_INC_ONE 2'h1
`define MCD_INC_TWO 2'h2
`define MCD_INC_DEC 2'h3
`define MCD_PRIO_LOW 2'h0
`define MCD_PRIO_NORM 2'h1
`define MCD_VL_PLUS1 3'h1
`define MCD_VL_EXACT 3'h2
`define MCD_VL_PLUS2 3'h3
`define MCD_VL_PLUS3 3'h4
// special register window inside the data space
`define MCD_SFR_LO 16'hdf80
`define MCD_SFR_HI 16'hdfff
`endif

// ==== src/mcd_arb.v ====
// mcd_arb.v: channel arbiter with priority classes and round-robin
`timescale 1ns/1ps
`default_nettype none
`include "mcd_defines.vh"
module mcd_arb #(
   parameter NCH = 5
) (
   // requests
   input wire [NCH-1:0] i_req,
   input wire [2*NCH-1:0] i_prio,
   input wire i_cpu_req,
   input wire i_normal_turn,
   input wire [2:0] i_last,
   // grant
   output reg o_valid,
   output reg [2:0] o_sel
);
   integer k;
   integer idx;
   reg [1:0] lvl [0:NCH-1];
   reg [NCH-1:0] elig;
   reg [1:0] best;
   // [R12] [R13] class filter then rotate
   always @* begin
      best = 2'h0;
      o_valid = 1'b0;
      o_sel = 3'h0;
      for (k = 0; k < NCH; k = k + 1) begin
         lvl[k] = i_prio[2*k +: 2];
         if (lvl[k] > 2'h2)
            lvl[k] = 2'h2;
         elig[k] = i_req[k] & ((lvl[k] == 2'h2) | ~i_cpu_req |
                   ((lvl[k] == `MCD_PRIO_NORM) & i_normal_turn));
         if (elig[k] && lvl[k] > best)
            best = lvl[k];
      end
      for (k = NCH; k >= 1; k = k - 1) begin
         idx = (i_last + k) % NCH;
         if (elig[idx] && lvl[idx] == best) begin
            o_valid = 1'b1;
            o_sel = idx[2:0];
         end
      end
   end
endmodule // mcd_arb
`default_nettype wire

// ==== src/mcd_dma.v ====
// mcd_dma.v: five-channel descriptor driven dma engine with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "mcd_defines.vh"
module mcd_dma #(
   parameter NCH = 5
) (
   // clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // shared memory arbiter port
   input wire i_cpu_req,
   input wire i_mem_gnt,
   input wire [7:0] i_mem_rdata,
   output reg o_mem_req,
   output reg o_mem_we,
   output reg [15:0] o_mem_addr,
   output reg [7:0] o_mem_wdata,
   // trigger pulses, bit n is trigger code n
   input wire [31:0] i_trig,
   // completion
   output reg [NCH-1:0] o_chan_done,
   output reg o_irq
);
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_FETCH = 4'b0010;
   localparam [3:0] ST_RD = 4'b0100;
   localparam [3:0] ST_WR = 4'b1000;

   reg [3:0] state_reg;
   reg [2:0] cur_reg;
   reg [2:0] bidx_reg;
   reg [15:0] data_reg;
   reg [2:0] last_reg;
   reg normal_turn_reg;
   reg [NCH-1:0] armed_reg;
   reg [NCH-1:0] cfg_valid_reg;
   reg [NCH-1:0] pend_reg;
   reg [NCH-1:0] flag_reg;
   reg [15:0] ptr0_reg;
   reg [15:0] ptr1_reg;
   reg [7:0] desc_mem [0:8*NCH-1];
   reg [15:0] src_ptr [0:NCH-1];
   reg [15:0] dst_ptr [0:NCH-1];
   reg [12:0] cnt_mem [0:NCH-1];
   reg [12:0] tgt_mem [0:NCH-1];
   integer i, j, m;

   function is_sfr;
      input [15:0] a;
      is_sfr = (a >= `MCD_SFR_LO) && (a <= `MCD_SFR_HI);
   endfunction

   // [R7] pointer step, scaled by element size
   function [15:0] step;
      input [15:0] a;
      input [1:0] inc;
      input word;
      case (inc)
         `MCD_INC_ONE: step = word ? a + 16'h0002 : a + 16'h0001;
         `MCD_INC_TWO: step = word ? a + 16'h0004 : a + 16'h0002;
         `MCD_INC_DEC: step = word ? a - 16'h0002 : a - 16'h0001;
         default: step = a;
      endcase
   endfunction

   // per-channel trigger code and priority
   wire [5*NCH-1:0] trig_code;
   wire [2*NCH-1:0] prio_vec;
   wire [NCH-1:0] hw_hit;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         assign trig_code[5*g +: 5] = desc_mem[8*g+6][4:0];
         assign prio_vec[2*g +: 2] = desc_mem[8*g+7][1:0];
         // [R8] [R23] one source, code 0 none, 1 previous
         assign hw_hit[g] = (trig_code[5*g +: 5] == `MCD_TRIG_PREV) ?
                            (g > 0 && o_chan_done[(g+NCH-1)%NCH]) :
                            (trig_code[5*g +: 5] != `MCD_TRIG_NONE) &&
                            i_trig[trig_code[5*g +: 5]];
      end
   endgenerate

   // current channel descriptor fields
   wire [7:0] cb4 = desc_mem[{cur_reg, 3'h4}];
   wire [7:0] cb5 = desc_mem[{cur_reg, 3'h5}];
   wire [7:0] cb6 = desc_mem[{cur_reg, 3'h6}];
   wire [7:0] cb7 = desc_mem[{cur_reg, 3'h7}];
   wire cword = cb6[`MCD_WORD_BIT];
   wire [1:0] ctmode = cb6[6:5];
   wire [2:0] cvlen = cb4[7:5];
   wire [12:0] len_cfg = {cb4[4:0], cb5};
   wire src_sfr = is_sfr(src_ptr[cur_reg]);
   wire dst_sfr = is_sfr(dst_ptr[cur_reg]);

   // [R20] byte placement: big-endian data space, little-endian sfr
   wire rd_hi = cword & ((bidx_reg == 3'h0) ^ src_sfr);
   wire [15:0] rd_merge = rd_hi ? {i_mem_rdata, data_reg[7:0]} :
                          {data_reg[15:8], i_mem_rdata};
   wire wr0_hi = cword & ~dst_sfr;

   // [R1] [R5] length taken from the first element
   wire [12:0] vl_n = cword ? data_reg[12:0] :
                      (cb7[`MCD_M8_BIT] ? {5'h00, data_reg[7:0]} :
                      {6'h00, data_reg[6:0]});
   reg [13:0] vl_tot;
   // [R4] total count per variable option
   always @* begin
      case (cvlen)
         `MCD_VL_PLUS1: vl_tot = {1'b0, vl_n} + 14'h0001;
         `MCD_VL_PLUS2: vl_tot = {1'b0, vl_n} + 14'h0002;
         `MCD_VL_PLUS3: vl_tot = {1'b0, vl_n} + 14'h0003;
         default: vl_tot = {1'b0, vl_n};
      endcase
   end
   wire vl_on = (cvlen >= `MCD_VL_PLUS1) && (cvlen <= `MCD_VL_PLUS3);
   // [R2] configured length is the ceiling
   wire [12:0] vl_cap = (vl_tot > {1'b0, len_cfg}) ? len_cfg : vl_tot[12:0];
   wire [12:0] cnt_new = cnt_mem[cur_reg] + 13'h0001;
   wire [12:0] tgt_now = (vl_on && cnt_mem[cur_reg] == 13'h0000) ?
                         vl_cap : tgt_mem[cur_reg];
   wire xfer_done = cnt_new >= tgt_now;
   wire rep_mode = ctmode[1];

   // [R14] [R15] descriptor fetch order 1..4 then 0
   wire [NCH-1:0] fetch_need = armed_reg & ~cfg_valid_reg;
   reg [2:0] fetch_ch;
   always @* begin
      fetch_ch = 3'h0;
      for (j = NCH - 1; j >= 1; j = j - 1)
         if (fetch_need[j])
            fetch_ch = j[2:0];
   end
   wire [15:0] fetch_base = (fetch_ch == 3'h0) ? ptr0_reg :
                            ptr1_reg + {10'h000, fetch_ch - 3'h1, 3'h0};

   wire arb_valid;
   wire [2:0] arb_sel;
   // [R12] transfer arbitration
   mcd_arb #(.NCH(NCH)) u_arb (
      .i_req(armed_reg & cfg_valid_reg & pend_reg),
      .i_prio(prio_vec),
      .i_cpu_req(i_cpu_req),
      .i_normal_turn(normal_turn_reg),
      .i_last(last_reg),
      .o_valid(arb_valid),
      .o_sel(arb_sel)
   );

   // apb strobes
   wire apb_wr = i_psel & i_penable & o_pready & i_pwrite;
   wire wr_arm = apb_wr && i_paddr == `MCD_A_ARM;
   wire wr_abort = wr_arm && i_pwdata[`MCD_ABORT_BIT];
   wire wr_sw = apb_wr && i_paddr == `MCD_A_SWREQ;
   wire cur_aborted = wr_abort && i_pwdata[cur_reg] && !state_reg[0];
   reg [NCH-1:0] irq_mask;
   always @* begin
      for (m = 0; m < NCH; m = m + 1)
         irq_mask[m] = desc_mem[8*m+7][`MCD_IRQM_BIT] & cfg_valid_reg[m];
   end

   // engine, registers and channel bookkeeping
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= ST_IDLE;
         cur_reg <= 3'h0;
         bidx_reg <= 3'h0;
         data_reg <= 16'h0000;
         last_reg <= 3'h0;
         normal_turn_reg <= 1'b0;
         armed_reg <= {NCH{1'b0}};
         cfg_valid_reg <= {NCH{1'b0}};
         pend_reg <= {NCH{1'b0}};
         flag_reg <= {NCH{1'b0}};
         ptr0_reg <= `MCD_PTR_RST;
         ptr1_reg <= `MCD_PTR_RST;
         o_prdata <= 32'h00000000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_mem_req <= 1'b0;
         o_mem_we <= 1'b0;
         o_mem_addr <= 16'h0000;
         o_mem_wdata <= 8'h00;
         o_chan_done <= {NCH{1'b0}};
         o_irq <= 1'b0;
         for (i = 0; i < NCH; i = i + 1) begin
            src_ptr[i] <= 16'h0000;
            dst_ptr[i] <= 16'h0000;
            cnt_mem[i] <= 13'h0000;
            tgt_mem[i] <= 13'h0000;
         end
      end else begin
         o_chan_done <= {NCH{1'b0}};
         o_pslverr <= 1'b0;
         o_pready <= i_psel & ~i_penable;
         o_irq <= |(flag_reg & irq_mask);
         // [R21] [R22] triggers count only once configured
         pend_reg <= pend_reg | (armed_reg & cfg_valid_reg &
                     (hw_hit | (wr_sw ? i_pwdata[NCH-1:0] : {NCH{1'b0}})));
         // apb read data captured in the setup phase
         if (i_psel && !i_penable) begin
            case (i_paddr)
               `MCD_A_ARM: o_prdata <= {27'h0, armed_reg};
               `MCD_A_SWREQ: o_prdata <= {27'h0, pend_reg};
               `MCD_A_FLAG: o_prdata <= {27'h0, flag_reg};
               `MCD_A_PTR0: o_prdata <= {16'h0, ptr0_reg};
               `MCD_A_PTR1: o_prdata <= {16'h0, ptr1_reg};
               `MCD_A_STAT: o_prdata <= {20'h0, state_reg, cur_reg, cfg_valid_reg};
               default: begin
                  o_prdata <= 32'h00000000;
                  o_pslverr <= 1'b1;
               end
            endcase
         end
         if (apb_wr && i_paddr == `MCD_A_PTR0)
            ptr0_reg <= i_pwdata[15:0];
         if (apb_wr && i_paddr == `MCD_A_PTR1)
            ptr1_reg <= i_pwdata[15:0];
         // completion flags: write one clears
         if (apb_wr && i_paddr == `MCD_A_FLAG)
            flag_reg <= flag_reg & ~i_pwdata[NCH-1:0];

         case (state_reg)
            ST_IDLE: begin
               bidx_reg <= 3'h0;
               data_reg <= 16'h0000;
               if (|fetch_need) begin
                  cur_reg <= fetch_ch;
                  state_reg <= ST_FETCH;
                  o_mem_req <= 1'b1;
                  o_mem_we <= 1'b0;
                  o_mem_addr <= fetch_base;
               end else if (arb_valid) begin
                  cur_reg <= arb_sel;
                  last_reg <= arb_sel;
                  // [R13] normal class takes every second contention
                  if (i_cpu_req && prio_vec[2*arb_sel +: 2] == `MCD_PRIO_NORM)
                     normal_turn_reg <= 1'b0;
                  else if (i_cpu_req)
                     normal_turn_reg <= 1'b1;
                  state_reg <= ST_RD;
                  o_mem_req <= 1'b1;
                  o_mem_we <= 1'b0;
                  o_mem_addr <= src_ptr[arb_sel];
               end else if (i_cpu_req)
                  normal_turn_reg <= 1'b1;
            end
            ST_FETCH: if (i_mem_gnt) begin
               desc_mem[{cur_reg, bidx_reg}] <= i_mem_rdata;
               o_mem_addr <= o_mem_addr + 16'h0001;
               bidx_reg <= bidx_reg + 3'h1;
               if (bidx_reg == `MCD_DESC_LAST) begin
                  // [R6] [R24] working pointers from bytes 0-3
                  src_ptr[cur_reg] <= {desc_mem[{cur_reg, 3'h0}],
                                       desc_mem[{cur_reg, 3'h1}]};
                  dst_ptr[cur_reg] <= {desc_mem[{cur_reg, 3'h2}],
                                       desc_mem[{cur_reg, 3'h3}]};
                  cnt_mem[cur_reg] <= 13'h0000;
                  tgt_mem[cur_reg] <= len_cfg;
                  cfg_valid_reg[cur_reg] <= 1'b1;
                  pend_reg[cur_reg] <= 1'b0;
                  o_mem_req <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_RD: if (i_mem_gnt) begin
               data_reg <= rd_merge;
               // [R11] second read only for words
               if (cword && bidx_reg == 3'h0) begin
                  bidx_reg <= 3'h1;
                  o_mem_addr <= src_ptr[cur_reg] + 16'h0001;
               end else begin
                  // [R25] write follows the completed read
                  bidx_reg <= 3'h0;
                  state_reg <= ST_WR;
                  o_mem_we <= 1'b1;
                  o_mem_addr <= dst_ptr[cur_reg];
                  o_mem_wdata <= wr0_hi ? rd_merge[15:8] : rd_merge[7:0];
               end
            end
            ST_WR: if (i_mem_gnt) begin
               if (cword && bidx_reg == 3'h0) begin
                  bidx_reg <= 3'h1;
                  o_mem_addr <= dst_ptr[cur_reg] + 16'h0001;
                  o_mem_wdata <= wr0_hi ? data_reg[7:0] : data_reg[15:8];
               end else begin
                  o_mem_req <= 1'b0;
                  o_mem_we <= 1'b0;
                  state_reg <= ST_IDLE;
                  src_ptr[cur_reg] <= step(src_ptr[cur_reg], cb7[7:6], cword);
                  dst_ptr[cur_reg] <= step(dst_ptr[cur_reg], cb7[5:4], cword);
                  cnt_mem[cur_reg] <= cnt_new;
                  tgt_mem[cur_reg] <= tgt_now;
                  // [R9] single modes consume the trigger each transfer
                  if (ctmode == `MCD_TM_SINGLE || ctmode == `MCD_TM_RSINGLE)
                     pend_reg[cur_reg] <= 1'b0;
                  if (xfer_done) begin
                     // [R10] block modes run until the count is reached
                     pend_reg[cur_reg] <= 1'b0;
                     o_chan_done[cur_reg] <= 1'b1;
                     // [R18] flag set whatever the mask
                     flag_reg[cur_reg] <= 1'b1;
                     if (rep_mode) begin
                        // [R6] rearm reloads working pointers
                        src_ptr[cur_reg] <= {desc_mem[{cur_reg, 3'h0}],
                                             desc_mem[{cur_reg, 3'h1}]};
                        dst_ptr[cur_reg] <= {desc_mem[{cur_reg, 3'h2}],
                                             desc_mem[{cur_reg, 3'h3}]};
                        cnt_mem[cur_reg] <= 13'h0000;
                        tgt_mem[cur_reg] <= len_cfg;
                     end else begin
                        armed_reg[cur_reg] <= 1'b0;
                        cfg_valid_reg[cur_reg] <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               o_mem_req <= 1'b0;
            end
         endcase

         // [R16] abort disarms the written channels
         if (wr_abort) begin
            armed_reg <= armed_reg & ~i_pwdata[NCH-1:0];
            cfg_valid_reg <= cfg_valid_reg & ~i_pwdata[NCH-1:0];
            pend_reg <= pend_reg & ~i_pwdata[NCH-1:0];
            if (cur_aborted) begin
               state_reg <= ST_IDLE;
               o_mem_req <= 1'b0;
               o_mem_we <= 1'b0;
            end
         end else if (wr_arm) begin
            // [R14] arming forces a fresh descriptor fetch
            armed_reg <= armed_reg | i_pwdata[NCH-1:0];
            cfg_valid_reg <= cfg_valid_reg & ~i_pwdata[NCH-1:0];
         end
      end
   end
endmodule // mcd_dma
`default_nettype wire

// ==== testbench/mcd_dma_assertions.sv ====
// mcd_dma_assertions.sv: port level checks for the dma engine
`timescale 1ns/1ps
`default_nettype none
`include "mcd_defines.vh"
module mcd_dma_checker #(
   parameter NCH = 5
) (
   // clock, reset and apb
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // memory port and completion
   input wire logic i_mem_gnt,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [15:0] o_mem_addr,
   input wire logic [7:0] o_mem_wdata,
   input wire logic [NCH-1:0] o_chan_done
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire abort_all;
   // abort of every channel taking effect this edge
   assign abort_all = i_psel && i_penable && o_pready && i_pwrite && i_paddr == `MCD_A_ARM
      && i_pwdata[`MCD_ABORT_BIT] && i_pwdata[4:0] == 5'h1f;
   sequence s_wr_done;
      o_mem_req && o_mem_we && i_mem_gnt;
   endsequence
   sequence s_quiet;
      !o_mem_req [*4];
   endsequence
   a_req_held: assert property (o_mem_req && !i_mem_gnt && !abort_all |=> o_mem_req
      && $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_wdata))
      else $error("memory request changed before grant");
   a_write_after_read: assert property (o_mem_req && o_mem_we && !$past(o_mem_we)
      |-> $past(o_mem_req && !o_mem_we && i_mem_gnt))
      else $error("write issued without a completed read");
   a_idle_after_write: assert property (s_wr_done |=> !o_mem_req || o_mem_we)
      else $error("no idle cycle after a transfer");
   a_done_after_write: assert property (|o_chan_done |-> $past(o_mem_req && o_mem_we && i_mem_gnt))
      else $error("completion without a final write");
   a_done_one_cycle: assert property (|o_chan_done |=> !(|o_chan_done))
      else $error("completion pulse too long");
   a_abort_quiet: assert property (abort_all |=> ##1 s_quiet)
      else $error("memory request after abort");
   a_pready_once: assert property (o_pready |=> !o_pready)
      else $error("ready held more than one cycle");
   a_pready_setup: assert property (o_pready |-> $past(i_psel && !i_penable) && i_psel && i_penable)
      else $error("ready without a setup cycle");
   a_slverr_unmapped: assert property (o_pslverr |-> o_pready
      && (i_paddr > `MCD_A_STAT || i_paddr[1:0] != 2'h0))
      else $error("error response on a mapped address");
endmodule // mcd_dma_checker
bind mcd_dma mcd_dma_checker #(.NCH(NCH)) i_mcd_dma_checker (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_mem_gnt(i_mem_gnt), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
   .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_chan_done(o_chan_done));
`default_nettype wire

// ==== testbench/mcd_mem_model.sv ====
// mcd_mem_model.sv: shared memory and arbiter model facing the dma engine
`timescale 1ns/1ps
`default_nettype none
module mcd_mem_model (
   // clock and stall control
   input wire logic i_clk,
   input wire logic i_stall,
   // engine request
   input wire logic i_mem_req,
   input wire logic i_mem_we,
   input wire logic [15:0] i_mem_addr,
   input wire logic [7:0] i_mem_wdata,
   // answer
   output logic o_mem_gnt,
   output logic [7:0] o_mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] junk_reg = 8'h5a;
   // grant one access per edge unless stalled
   assign o_mem_gnt = i_mem_req && !i_stall;
   // read data only while a read is granted
   assign o_mem_rdata = (o_mem_gnt && !i_mem_we) ? mem[i_mem_addr] : junk_reg;
   // write on grant, churn the idle data
   always @(posedge i_clk) begin
      junk_reg <= ~junk_reg + 8'h01;
      if (o_mem_gnt && i_mem_we) begin
         mem[i_mem_addr] <= i_mem_wdata;
      end
   end
endmodule // mcd_mem_model
`default_nettype wire

// ==== testbench/tb_multi_channel_dma_config.sv ====
// tb_multi_channel_dma_config.sv: self-checking bench for the dma engine
`timescale 1ns/1ps
`default_nettype none
`include "mcd_defines.vh"
module tb_multi_channel_dma_config;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_req = 1'b0, stall = 1'b0, slv;
   logic pready, pslverr, mem_req, mem_we, mem_gnt, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, trig = 32'h0, prdata, rd;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [4:0] done;
   int err_total = 0, n_tests = 0;
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   mcd_dma #(.NCH(5)) i_mcd_dma (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cpu_req(cpu_req),
      .i_mem_gnt(mem_gnt), .i_mem_rdata(mem_rdata), .o_mem_req(mem_req), .o_mem_we(mem_we),
      .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_trig(trig), .o_chan_done(done),
      .o_irq(irq));
   mcd_mem_model i_mcd_mem_model (.i_clk(i_clk), .i_stall(stall), .i_mem_req(mem_req),
      .i_mem_we(mem_we), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .o_mem_gnt(mem_gnt),
      .o_mem_rdata(mem_rdata));
   // verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic mchk(input logic [15:0] a, input logic [7:0] e);
      chk({24'h0, i_mcd_mem_model.mem[a]}, {24'h0, e});
   endtask
   // apb transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         err_total++;
         results();
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic fill(input logic [15:0] b, input int n, input logic [7:0] v0, input int st);
      for (int i = 0; i < n; i++) i_mcd_mem_model.mem[b + 16'(i)] = v0 + 8'(st * i);
   endtask
   // channel 0 descriptor at its pointer
   task automatic desc(input logic [15:0] s, input logic [15:0] d, input logic [2:0] vl,
      input logic [12:0] len, input logic [7:0] b6, input logic [7:0] b7);
      logic [7:0] v [8];
      v = '{s[15:8], s[7:0], d[15:8], d[7:0], {vl, len[12:8]}, len[7:0], b6, b7};
      for (int i = 0; i < 8; i++) i_mcd_mem_model.mem[16'h0100 + 16'(i)] = v[i];
   endtask
   task automatic pulse(input int n);
      @(posedge i_clk);
      trig <= 32'h1 << n;
      @(posedge i_clk);
      trig <= 32'h0;
   endtask
   task automatic wait_done();
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge i_clk);
         if (done[0] === 1'b1) break;
      end
      if (k == 400) begin
         err_total++;
         results();
      end
   endtask
   // arm, let the fetch finish, then request by software
   task automatic go();
      apb(1'b1, `MCD_A_ARM, 32'h1);
      repeat (12) @(posedge i_clk);
      apb(1'b1, `MCD_A_SWREQ, 32'h1);
      wait_done();
   endtask
   task automatic t_regs();
      rdchk(`MCD_A_ARM, 32'h0);
      rdchk(`MCD_A_PTR0, 32'h0);
      apb(1'b1, `MCD_A_PTR0, 32'hffff0100);
      rdchk(`MCD_A_PTR0, 32'h100);
      apb(1'b1, `MCD_A_PTR1, 32'h0140);
      rdchk(`MCD_A_PTR1, 32'h140);
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, slv}, 32'h1);
      $display("test registers done");
   endtask
   task automatic t_block();
      desc(16'h0200, 16'h0300, 3'h0, 13'd4, 8'h20, 8'h52);
      fill(16'h0200, 8, 8'h10, 1);
      fill(16'h0300, 8, 8'h00, 0);
      go();
      for (int i = 0; i < 5; i++) mchk(16'h0300 + 16'(i), i < 4 ? 8'h10 + 8'(i) : 8'h00);
      rdchk(`MCD_A_ARM, 32'h0);
      rdchk(`MCD_A_FLAG, 32'h1);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `MCD_A_FLAG, 32'h1);
      rdchk(`MCD_A_FLAG, 32'h0);
      $display("test byte block done");
   endtask
   task automatic t_word();
      desc(16'h0200, `MCD_SFR_LO, 3'h0, 13'd2, 8'ha0, 8'h52);
      fill(`MCD_SFR_LO, 5, 8'h00, 0);
      go();
      mchk(16'hdf80, 8'h11);
      mchk(16'hdf81, 8'h10);
      mchk(16'hdf82, 8'h13);
      mchk(16'hdf84, 8'h00);
      apb(1'b1, `MCD_A_FLAG, 32'h1);
      $display("test word endian done");
   endtask
   task automatic t_var_length_mode();
      logic [2:0] vl [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h2, 3'h2};
      logic [7:0] fb [7] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h14, 8'h83, 8'h83};
      logic m8 [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      int exp_n [7] = '{4, 3, 5, 6, 10, 3, 10};
      int n;
      cpu_req <= 1'b1;
      for (int c = 0; c < 7; c++) begin
         desc(16'h0200, 16'h0300, vl[c], 13'd10, 8'h20, {5'h0a, m8[c], 2'h1});
         fill(16'h0200, 16, 8'h40, 1);
         i_mcd_mem_model.mem[16'h0200] = fb[c];
         fill(16'h0300, 16, 8'h00, 0);
         go();
         n = 0;
         for (int i = 0; i < 16; i++) n += (i_mcd_mem_model.mem[16'h0300 + 16'(i)] != 8'h00);
         chk(32'(n), 32'(exp_n[c]));
         apb(1'b1, `MCD_A_FLAG, 32'h1);
      end
      cpu_req <= 1'b0;
      $display("test variable length done");
   endtask
   task automatic t_trig();
      desc(16'h0200, 16'h0308, 3'h0, 13'd2, 8'h45, 8'h7a);
      fill(16'h0200, 4, 8'h10, 1);
      fill(16'h0300, 16, 8'h00, 0);
      apb(1'b1, `MCD_A_ARM, 32'h1);
      pulse(5);
      repeat (12) @(posedge i_clk);
      pulse(6);
      repeat (10) @(posedge i_clk);
      mchk(16'h0308, 8'h00);
      pulse(5);
      repeat (10) @(posedge i_clk);
      mchk(16'h0308, 8'h10);
      mchk(16'h0307, 8'h00);
      pulse(5);
      wait_done();
      mchk(16'h0307, 8'h11);
      rdchk(`MCD_A_ARM, 32'h1);
      chk({31'h0, irq}, 32'h1);
      fill(16'h0308, 1, 8'h00, 0);
      repeat (12) @(posedge i_clk);
      pulse(5);
      repeat (10) @(posedge i_clk);
      mchk(16'h0308, 8'h10);
      // clear the stale flag, then abort the channel
      apb(1'b1, `MCD_A_FLAG, 32'h1);
      repeat (2) @(posedge i_clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `MCD_A_ARM, 32'h81);
      rdchk(`MCD_A_ARM, 32'h0);
      $display("test triggers done");
   endtask
   task automatic t_abort();
      desc(16'h0200, 16'h0300, 3'h0, 13'd8, 8'h20, 8'h52);
      fill(16'h0300, 8, 8'h00, 0);
      apb(1'b1, `MCD_A_ARM, 32'h1);
      repeat (12) @(posedge i_clk);
      stall <= 1'b1;
      apb(1'b1, `MCD_A_SWREQ, 32'h1);
      repeat (5) @(posedge i_clk);
      apb(1'b1, `MCD_A_ARM, 32'h9f);
      stall <= 1'b0;
      repeat (10) @(posedge i_clk);
      rdchk(`MCD_A_ARM, 32'h0);
      rdchk(`MCD_A_FLAG, 32'h0);
      mchk(16'h0300, 8'h00);
      $display("test abort done");
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_regs();
      t_block();
      t_word();
      t_var_length_mode();
      t_trig();
      t_abort();
      results();
   end
endmodule // tb_multi_channel_dma_config
`default_nettype wire
